// ==== rtl/hcap_pkg.sv ====
// Shared constants for the host access port
package hcap_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int HI_ADDR_W = 3;
    localparam int SER_FRAME_BITS = 20;
    localparam int SER_ADDR_LSB = 8;
    localparam int SER_RW_POS = 19;
    localparam int WAIT_CYCLES = 2;
    localparam logic [10:0] ADDR_RESET = 11'h000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    typedef enum logic [1:0] {HCAP_IDLE, HCAP_WAIT, HCAP_DONE} hcap_state_e;
endpackage

// ==== rtl/hcap_sync.sv ====
// Two-flop synchroniser with edge detection after the second stage
`timescale 1ns/1ps
module hcap_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut,
    output logic [W-1:0] riseOut,
    output logic [W-1:0] fallOut
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;
    logic [W-1:0] stage3_ff;

    // Stage one read only by stage two
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
        end
        else
        begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Level and edges from the settled stages
    assign syncOut = stage2_ff;
    assign riseOut = stage2_ff & ~stage3_ff;
    assign fallOut = ~stage2_ff & stage3_ff;
endmodule

// ==== rtl/hcap_port.sv ====
// Host processor access port: parallel strobe styles and serial shift mode
`timescale 1ns/1ps
module hcap_port (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic parallel_sel,
    input wire logic bus_style_strap,
    input wire logic bus_form_select,
    input wire logic chipSel_n,
    input wire logic address_capture_strobe,
    input wire logic strobe_n,
    input wire logic dirOrWrite,
    input wire logic [10:0] addrIn,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic handshakeOut,
    output logic [10:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrite,
    output logic regRead,
    input wire logic [7:0] regRdData
);
    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [5:0] pinsSync;
    logic [5:0] pinsRise;
    logic [5:0] pinsFall;
    logic [7:0] dataSync;
    logic [10:0] addrSync;
    logic [2:0] strapSync;

    hcap_sync #(.W(6)) uSyncCtl (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .asyncIn({chipSel_n, address_capture_strobe, strobe_n, dirOrWrite,
                  1'b0, 1'b0}),
        .syncOut(pinsSync),
        .riseOut(pinsRise),
        .fallOut(pinsFall)
    );
    hcap_sync #(.W(22)) uSyncBus (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .asyncIn({parallel_sel, bus_style_strap, bus_form_select, addrIn, dataIn}),
        .syncOut({strapSync, addrSync, dataSync}),
        .riseOut(),
        .fallOut()
    );

    wire csN = pinsSync[5];
    wire latchFall = pinsFall[4];
    wire strN = pinsSync[3];
    wire strFall = pinsFall[3];
    wire rwLevel = pinsSync[2];
    wire rwFall = pinsFall[2];
    wire isParallel = strapSync[2];
    wire isSepStyle = strapSync[1];
    wire isMux = strapSync[0];

    // ----------------------------------------
    // Parallel access decode
    // ----------------------------------------
    // Read/write requests for each bus style
    wire sepRead = isSepStyle & ~csN & ~strN;
    wire sepWrite = isSepStyle & ~csN & ~rwLevel;
    wire dsActive = ~isSepStyle & ~csN & ~strN;
    wire accRead = isParallel & (sepRead | (dsActive & rwLevel));
    wire accWrite = isParallel & (sepWrite | (dsActive & ~rwLevel));
    wire accStart = isParallel & ((isSepStyle & (strFall | rwFall)) |
                    (~isSepStyle & strFall)) & ~csN;
    wire accEnd = csN | (isSepStyle ? (strN & rwLevel) : strN);

    hcap_pkg::hcap_state_e state_ff;
    hcap_pkg::hcap_state_e nxt_state;
    logic [1:0] waitCnt_ff;
    logic [10:0] muxAddr_ff;
    logic isRead_ff;

    // Access sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            hcap_pkg::HCAP_IDLE: if (accStart) nxt_state = hcap_pkg::HCAP_WAIT;
            hcap_pkg::HCAP_WAIT:
            begin
                if (accEnd) nxt_state = hcap_pkg::HCAP_IDLE;
                else if (waitCnt_ff == 2'(hcap_pkg::WAIT_CYCLES - 1))
                    nxt_state = hcap_pkg::HCAP_DONE;
            end
            hcap_pkg::HCAP_DONE: if (accEnd) nxt_state = hcap_pkg::HCAP_IDLE;
            default: nxt_state = hcap_pkg::HCAP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_ff <= hcap_pkg::HCAP_IDLE;
            waitCnt_ff <= 2'h0;
            isRead_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            waitCnt_ff <= (state_ff == hcap_pkg::HCAP_WAIT) ? waitCnt_ff + 2'h1 : 2'h0;
            if (state_ff == hcap_pkg::HCAP_IDLE && accStart)
                isRead_ff <= accRead;
        end
    end

    // Address capture on the latch falling edge
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            muxAddr_ff <= hcap_pkg::ADDR_RESET;
        else if (isParallel && isMux && latchFall)
            muxAddr_ff <= {addrSync[10:8], dataSync};
    end

    wire [10:0] parAddr = isMux ? muxAddr_ff : addrSync;
    wire parDone = state_ff == hcap_pkg::HCAP_DONE;
    wire parWrPulse = (state_ff == hcap_pkg::HCAP_WAIT) && (nxt_state == hcap_pkg::HCAP_DONE)
                      && !isRead_ff && accWrite;
    wire parRdPulse = (state_ff == hcap_pkg::HCAP_IDLE) && accStart && accRead;

    // ----------------------------------------
    // Serial shift port
    // ----------------------------------------
    wire sclkRise = pinsRise[3];
    wire sclkFall = pinsFall[3];
    wire sdiLevel = pinsSync[2];
    logic [4:0] bitCnt_ff;
    logic [18:0] shiftIn_ff;
    logic [7:0] shiftOut_ff;
    logic serOut_ff;
    logic serRd_ff;
    logic serWr_ff;

    // Shift in on rising edges, out on falling edges
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || isParallel || csN)
        begin
            bitCnt_ff <= 5'h00;
            shiftIn_ff <= 19'h00000;
            shiftOut_ff <= hcap_pkg::DATA_RESET;
            serOut_ff <= 1'b0;
            serRd_ff <= 1'b0;
            serWr_ff <= 1'b0;
        end
        else
        begin
            serRd_ff <= 1'b0;
            serWr_ff <= 1'b0;
            if (sclkRise && bitCnt_ff < 5'(hcap_pkg::SER_FRAME_BITS))
            begin
                shiftIn_ff <= {shiftIn_ff[17:0], sdiLevel};
                bitCnt_ff <= bitCnt_ff + 5'h01;
                serRd_ff <= (bitCnt_ff == 5'(hcap_pkg::ADDR_W)) && shiftIn_ff[10];
                serWr_ff <= (bitCnt_ff == 5'(hcap_pkg::SER_FRAME_BITS - 1)) && !shiftIn_ff[18];
            end
            if (serRd_ff)
                shiftOut_ff <= regRdData;
            else if (sclkFall && bitCnt_ff > 5'(hcap_pkg::ADDR_W)) // Every fall after address
            begin
                serOut_ff <= shiftOut_ff[7];
                shiftOut_ff <= {shiftOut_ff[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [7:0] dataOut_ff;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dataOut_ff <= hcap_pkg::DATA_RESET;
        end
        else
        begin
            dataOut_ff <= regRdData;
        end
    end

    assign dataOut = dataOut_ff;
    assign dataOe = isParallel && accRead && !accEnd && !(isMux && !isRead_ff);
    // Ready low while waiting; acknowledge low once done
    assign handshakeOut = !isParallel ? serOut_ff :
                          isSepStyle ? !(state_ff == hcap_pkg::HCAP_WAIT) :
                          !(parDone && !accEnd);
    // Serial address sits higher once the data byte has shifted in behind it
    wire serFull = bitCnt_ff == 5'(hcap_pkg::SER_FRAME_BITS);
    wire [10:0] serAddr = serFull ? shiftIn_ff[hcap_pkg::SER_ADDR_LSB +: 11] :
                          shiftIn_ff[10:0];
    assign regAddr = isParallel ? parAddr : serAddr;
    assign regWrData = isParallel ? dataSync : shiftIn_ff[7:0];
    assign regWrite = isParallel ? parWrPulse : serWr_ff;
    assign regRead = isParallel ? parRdPulse : serRd_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_ready_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (isParallel && isSepStyle && state_ff == hcap_pkg::HCAP_WAIT) |-> !handshakeOut)
        else $error("ready high during wait");
    chk_ack_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (isParallel && !isSepStyle && csN) |-> handshakeOut)
        else $error("ack held after deselect");
    chk_bus_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
        csN |-> !dataOe)
        else $error("bus driven while deselected");
    chk_wait_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_ff == hcap_pkg::HCAP_IDLE && nxt_state == hcap_pkg::HCAP_WAIT)
        |-> ##[1:3] (state_ff != hcap_pkg::HCAP_WAIT))
        else $error("wait too long");
    chk_mux_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (isParallel && isMux && latchFall) |=> muxAddr_ff == $past({addrSync[10:8], dataSync}))
        else $error("address not latched");
    chk_ser_shift: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!isParallel && !csN && sclkRise && bitCnt_ff < 5'(hcap_pkg::SER_FRAME_BITS))
        |=> shiftIn_ff[0] == $past(sdiLevel))
        else $error("serial bit missed");
    chk_ser_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!isParallel && !sclkFall) |=> $stable(serOut_ff) || $past(csN))
        else $error("serial out moved off falling edge");
    chk_plain_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (isParallel && !isMux) |-> regAddr == addrSync)
        else $error("plain address wrong");
    cov_sep_read: cover property (@(posedge clk_sys) isParallel && isSepStyle && regRead);
    cov_ds_write: cover property (@(posedge clk_sys) isParallel && !isSepStyle && regWrite);
    cov_ser_write: cover property (@(posedge clk_sys) !isParallel && regWrite);
endmodule

// ==== verif/hcap_host_model.sv ====
// Host bus master model that drives the access port pins
`timescale 1ns/1ps
module hcap_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic handshakeOut,
    output logic chipSel_n,
    output logic address_capture_strobe,
    output logic strobe_n,
    output logic dirOrWrite,
    output logic [10:0] addrIn,
    output logic [7:0] dataIn
);
    logic [7:0] hostData = 8'h00;
    logic hostOe = 1'b0;
    // Bus level, released bus shows the inverse of the last value
    assign dataIn = dataOe ? dataOut : (hostOe ? hostData : ~hostData);
    // Idle levels
    initial
    begin
        chipSel_n = 1'b1;
        address_capture_strobe = 1'b1;
        strobe_n = 1'b1;
        dirOrWrite = 1'b1;
        addrIn = 11'h000;
    end
    // Wait n edges, then step off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // One parallel access in either strobe style
    task automatic par(input logic ds, input logic mux, input logic rd,
        input logic [10:0] a, input logic [7:0] wd, output logic [7:0] rdv, output logic to);
        int n;
        chipSel_n = 1'b0;
        addrIn = mux ? {a[10:8], 8'hff} : a;
        hostData = a[7:0];
        hostOe = 1'b1;
        if (mux)
        begin
            cyc(4);
            address_capture_strobe = 1'b0;
            cyc(4);
        end
        hostData = wd;
        hostOe = !rd;
        if (ds)
            dirOrWrite = rd;
        else
            dirOrWrite = rd;
        strobe_n = !(ds || rd);
        n = 0;
        while (handshakeOut === !ds && n < 10)
        begin
            cyc(1);
            n++;
        end
        while (handshakeOut !== !ds && n < 40)
        begin
            cyc(1);
            n++;
        end
        // Hold through the edge that sees the answer, then read the shared bus
        cyc(1);
        rdv = dataIn;
        to = (n >= 40);
        strobe_n = 1'b1;
        dirOrWrite = 1'b1;
        hostOe = 1'b0;
        cyc(6);
        chipSel_n = 1'b1;
        address_capture_strobe = 1'b1;
        cyc(6);
    endtask
    // One serial frame, read flag, address, data, first bit most significant
    task automatic ser(input logic rd, input logic [10:0] a, input logic [7:0] wd,
        output logic [7:0] rdv);
        logic [19:0] f;
        f = {rd, a, wd};
        // Unused parallel address and data pins held at ground in serial mode
        addrIn = 11'h000;
        hostData = 8'h00;
        hostOe = 1'b1;
        chipSel_n = 1'b0;
        cyc(5);
        for (int i = 19; i >= 0; i--)
        begin
            strobe_n = 1'b0;
            dirOrWrite = f[i];
            cyc(5);
            if (i < 8)
                rdv[i] = handshakeOut;
            strobe_n = 1'b1;
            cyc(5);
        end
        chipSel_n = 1'b1;
        cyc(10);
    endtask
endmodule

// ==== verif/hcap_port_tb_top.sv ====
// Self-checking bench for the host access port
`timescale 1ns/1ps
module hcap_port_tb_top;
    logic clk_sys, sys_rst, parallel_sel, bus_style_strap, bus_form_select;
    logic chipSel_n, acs, strobe_n, dirOrWrite, dataOe, handshakeOut, regWrite, regRead;
    logic [10:0] addrIn, regAddr, wrAddr;
    logic [7:0] dataIn, dataOut, regWrData, wrData, rdv;
    logic to;
    int fails = 0, cmpCount = 0, wrCnt = 0, rdCnt = 0, cycles = 0, wc, rc;
    logic [29:0] rows [8] = '{
        {3'h0, 11'h123, 8'h81, 8'h81}, {3'h1, 11'h7fe, 8'h00, 8'ha4},
        {3'h2, 11'h4a5, 8'h3c, 8'h3c}, {3'h3, 11'h201, 8'h00, 8'h5b},
        {3'h4, 11'h000, 8'hff, 8'hff}, {3'h5, 11'h3ff, 8'h00, 8'ha5},
        {3'h6, 11'h555, 8'h00, 8'h00}, {3'h7, 11'h6c3, 8'h00, 8'h99}};
    hcap_port u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .parallel_sel(parallel_sel),
        .bus_style_strap(bus_style_strap), .bus_form_select(bus_form_select),
        .chipSel_n(chipSel_n), .address_capture_strobe(acs), .strobe_n(strobe_n),
        .dirOrWrite(dirOrWrite), .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .handshakeOut(handshakeOut), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regAddr[7:0] ^ 8'h5a));
    hcap_host_model u_host (.clk_sys(clk_sys), .dataOut(dataOut), .dataOe(dataOe),
        .handshakeOut(handshakeOut), .chipSel_n(chipSel_n), .address_capture_strobe(acs),
        .strobe_n(strobe_n), .dirOrWrite(dirOrWrite), .addrIn(addrIn), .dataIn(dataIn));
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Register side capture and hang limit
    always @(posedge clk_sys)
    begin
        if (regWrite)
        begin
            wrCnt++;
            wrAddr = regAddr;
            wrData = regWrData;
        end
        if (regRead)
            rdCnt++;
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        parallel_sel = 1'b1;
        bus_style_strap = 1'b1;
        bus_form_select = 1'b0;
        u_host.cyc(20);
        sys_rst = 1'b0;
        u_host.cyc(6);
        check(16'({dataOe, handshakeOut}), 16'h1);
        foreach (rows[i])
        begin
            bus_style_strap = !rows[i][29];
            bus_form_select = rows[i][28];
            u_host.cyc(8);
            wc = wrCnt;
            rc = rdCnt;
            u_host.par(rows[i][29], rows[i][28], rows[i][27], rows[i][26:16],
                rows[i][15:8], rdv, to);
            check(16'(to), 16'h0);
            if (rows[i][27])
            begin
                check(16'(rdv), 16'(rows[i][7:0]));
                check(16'(rdCnt - rc), 16'h1);
            end
            else
            begin
                check(16'(wrAddr), 16'(rows[i][26:16]));
                check(16'(wrData), 16'(rows[i][7:0]));
                check(16'(wrCnt - wc), 16'h1);
            end
            check(16'({dataOe, handshakeOut}), 16'h1);
        end
        // Strobe without chip select is ignored
        wc = wrCnt + rdCnt;
        u_host.strobe_n = 1'b0;
        u_host.cyc(10);
        check(16'(wrCnt + rdCnt - wc), 16'h0);
        check(16'({dataOe, handshakeOut}), 16'h1);
        u_host.strobe_n = 1'b1;
        // Serial frames
        parallel_sel = 1'b0;
        bus_form_select = 1'b0;
        bus_style_strap = 1'b1;
        u_host.cyc(10);
        wc = wrCnt;
        rc = rdCnt;
        u_host.ser(1'b0, 11'h5a3, 8'hc6, rdv);
        check(16'(wrCnt - wc), 16'h1);
        check(16'(wrAddr), 16'h5a3);
        check(16'(wrData), 16'hc6);
        u_host.ser(1'b1, 11'h0f0, 8'h00, rdv);
        check(16'(wrCnt - wc), 16'h1);
        check(16'(rdCnt - rc), 16'h1);
        check(16'(rdv), 16'haa);
        test_done();
    end
endmodule
